/* File: shared/timer8_defines.svh */
`ifndef TIMER8_DEFINES_SVH
`define TIMER8_DEFINES_SVH

// apb byte addresses of the register map
`define ADDR_CTRL_A   12'h000
`define ADDR_CTRL_B   12'h004
`define ADDR_COUNTER  12'h008
`define ADDR_CMP_A    12'h00c
`define ADDR_CMP_B    12'h010
`define ADDR_MASK     12'h014
`define ADDR_FLAG     12'h018
`define ADDR_STATUS   12'h01c

// field positions
`define CTRLA_WGM0    0
`define CTRLA_WGM1    1
`define CTRLA_COMB_LO 4
`define CTRLA_COMA_LO 6
`define CTRLB_CS_LO   0
`define CTRLB_WGM2    3
`define CTRLB_FOCB    6
`define CTRLB_FOCA    7
`define FLAG_OVF      0
`define FLAG_MA       1
`define FLAG_MB       2

// counter limits and reset values
`define CNT_BOTTOM    8'h00
`define CNT_MAX       8'hff
`define RESET_BYTE    8'h00

// clock select codes
`define CS_STOP       3'h0
`define CS_EXT_FALL   3'h6
`define CS_EXT_RISE   3'h7

// waveform mode codes
`define WGM_NORMAL    3'h0
`define WGM_PC_FF     3'h1
`define WGM_CTC       3'h2
`define WGM_FAST_FF   3'h3
`define WGM_PC_OCA    3'h5
`define WGM_FAST_OCA  3'h7

// output action codes
`define COM_NONE      2'h0
`define COM_TOGGLE    2'h1
`define COM_CLEAR     2'h2
`define COM_SET       2'h3

`endif

/* File: shared/timer8_pkg.sv */
package timer8_pkg;
    // one compare channel's software-visible settings
    typedef struct packed {
        logic [1:0] action;
        logic force_strobe;
    } channel_ctrl_t;

    // counter direction during dual-slope modes
    typedef enum logic {dir_up, dir_down} count_dir_t;
endpackage

/* File: core/timer8_counter_compare_core.sv */
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "timer8_defines.svh"

// Summary of operation
// RULE1 - counter and compare values are 8 bits
// RULE2 - flag register with per-request mask bits
// RULE3 - tick from prescaled clock or pin edge
// RULE4 - clock select zero stops counter entirely
// RULE5 - bottom at 0x00, max at 0xff
// RULE6 - top is 0xff or compare a
// RULE7 - tick clears, increments or decrements counter
// RULE8 - cpu counter write beats count or clear
// RULE9 - mode from three waveform bits, two registers
// RULE10 - overflow flag per mode, can interrupt
// RULE11 - match sets flag at next tick
// RULE12 - flag clears on service or write-one
// RULE13 - outputs from match, mode, action, extremes
// RULE14 - compare buffered only in pwm modes
// RULE15 - buffer copied at top or bottom; code copies at top only
// RULE16 - cpu reaches buffer when buffering, else direct
// RULE17 - force strobe updates output, no flag
// RULE18 - counter write blocks next tick's match
// RULE19 - output states kept across mode change
// RULE20 - action bits take effect immediately
// RULE21 - software avoids writing counter equal compare
// RULE22 - software initialises outputs before pin enable
// RULE23 - reset clears output state registers
// RULE24 - normal mode wraps, overflow at zero
// RULE25 - reset clears counter, compares, buffers, flags
module timer8_counter_compare_core
    import timer8_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // prescaled tick from the shared prescaler, mclk domain
    input wire logic prescale_tick,
    // external count pin, asynchronous
    input wire logic ext_count_pin,
    // interrupt service acknowledges, one-cycle pulses
    input wire logic ack_overflow,
    input wire logic ack_match_a,
    input wire logic ack_match_b,
    // interrupt requests, masked
    output logic irq_overflow,
    output logic irq_match_a,
    output logic irq_match_b,
    // compare outputs and port override enables
    output logic wave_out_a,
    output logic wave_out_b,
    output logic wave_en_a,
    output logic wave_en_b
);

    logic [7:0] timer_control_a;
    logic [7:0] timer_control_b_reg;
    logic [7:0] counter_value;
    logic [7:0] compare_value_a;
    logic [7:0] compare_value_b;
    logic [7:0] buffer_a_reg;
    logic [7:0] buffer_b_reg;
    logic [2:0] timer_mask_reg;
    logic [2:0] timer_flag_reg;
    logic wave_a_reg;
    logic wave_b_reg;
    logic block_reg;
    count_dir_t dir_reg;
    logic [2:0] pin_sync_reg;
    logic pin_level_reg;

    // decoded controls
    logic [2:0] clock_select_field;
    logic [2:0] waveform_mode_field;
    logic pwm_mode;
    logic dual_slope;
    logic fast_mode;
    logic [7:0] top_value;
    logic timer_tick;
    logic at_top;
    logic at_bottom;
    logic match_a;
    logic match_b;
    logic [7:0] counter_next;
    count_dir_t dir_next;
    channel_ctrl_t chan_a;
    channel_ctrl_t chan_b;
    logic wr_en;
    logic wr_counter;
    logic wr_flag;
    logic wr_ctrl_b;

    // registers have no wait states
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign wr_counter = wr_en && paddr == `ADDR_COUNTER;
    assign wr_flag = wr_en && paddr == `ADDR_FLAG;
    assign wr_ctrl_b = wr_en && paddr == `ADDR_CTRL_B;

    // mode spans two registers
    assign clock_select_field = timer_control_b_reg[`CTRLB_CS_LO +: 3];
    assign waveform_mode_field = {timer_control_b_reg[`CTRLB_WGM2],
        timer_control_a[`CTRLA_WGM1], timer_control_a[`CTRLA_WGM0]}; // RULE9
    assign fast_mode = waveform_mode_field == `WGM_FAST_FF ||
        waveform_mode_field == `WGM_FAST_OCA;
    assign dual_slope = waveform_mode_field == `WGM_PC_FF ||
        waveform_mode_field == `WGM_PC_OCA;
    assign pwm_mode = fast_mode | dual_slope; // RULE14

    // top is fixed only where the mode does not name compare a
    assign top_value = (waveform_mode_field == `WGM_CTC ||
        waveform_mode_field == `WGM_PC_OCA ||
        waveform_mode_field == `WGM_FAST_OCA) ?
        compare_value_a : `CNT_MAX; // RULE6
    assign at_top = counter_value == top_value;
    assign at_bottom = counter_value == `CNT_BOTTOM; // RULE5

    // action bits act directly, never through the buffer
    assign chan_a = '{action: timer_control_a[`CTRLA_COMA_LO +: 2],
        force_strobe: wr_ctrl_b & pwdata[`CTRLB_FOCA]}; // RULE20
    assign chan_b = '{action: timer_control_a[`CTRLA_COMB_LO +: 2],
        force_strobe: wr_ctrl_b & pwdata[`CTRLB_FOCB]};

    // pin synchroniser: first stage read only by the second
    always_ff @(posedge mclk) begin
        if (reset) begin
            pin_sync_reg <= 3'h0;
        end else begin
            pin_sync_reg <= {pin_sync_reg[1:0], ext_count_pin};
        end
    end

    // a level counts once stages two and three agree
    always_ff @(posedge mclk) begin
        if (reset) begin
            pin_level_reg <= 1'b0;
        end else if (pin_sync_reg[1] == pin_sync_reg[2]) begin
            pin_level_reg <= pin_sync_reg[2];
        end
    end

    // tick source and edge selection
    always_comb begin
        timer_tick = 1'b0;
        case (clock_select_field)
            `CS_STOP: timer_tick = 1'b0; // RULE4
            `CS_EXT_FALL: timer_tick = pin_level_reg & ~pin_sync_reg[2] &
                ~pin_sync_reg[1]; // RULE3
            `CS_EXT_RISE: timer_tick = ~pin_level_reg & pin_sync_reg[2] &
                pin_sync_reg[1]; // RULE3
            default: timer_tick = prescale_tick; // RULE3
        endcase
    end

    assign match_a = counter_value == compare_value_a;
    assign match_b = counter_value == compare_value_b;

    // next count value and direction
    always_comb begin
        counter_next = counter_value;
        dir_next = dir_reg;
        if (dual_slope) begin
            if (dir_reg == dir_up && at_top) begin
                dir_next = dir_down;
                counter_next = counter_value - 8'h01;
            end else if (dir_reg == dir_down && at_bottom) begin
                dir_next = dir_up;
                counter_next = counter_value + 8'h01;
            end else if (dir_reg == dir_up) begin
                counter_next = counter_value + 8'h01;
            end else begin
                counter_next = counter_value - 8'h01; // RULE7
            end
        end else if (at_top && waveform_mode_field != `WGM_NORMAL) begin
            counter_next = `CNT_BOTTOM; // RULE7
        end else begin
            counter_next = counter_value + 8'h01; // RULE24
        end
    end

    // counter: cpu write wins over any tick
    always_ff @(posedge mclk) begin
        if (reset) begin
            counter_value <= `RESET_BYTE; // RULE25
            dir_reg <= dir_up;
        end else if (wr_counter) begin
            counter_value <= pwdata[7:0]; // RULE8 RULE1
        end else if (timer_tick) begin
            counter_value <= counter_next; // RULE7
            dir_reg <= dir_next;
        end
    end

    // block holds until the tick after a counter write, even if stopped
    always_ff @(posedge mclk) begin
        if (reset) begin
            block_reg <= 1'b0;
        end else if (wr_counter) begin
            block_reg <= 1'b1; // RULE18
        end else if (timer_tick) begin
            block_reg <= 1'b0;
        end
    end

    // control and mask registers
    always_ff @(posedge mclk) begin
        if (reset) begin
            timer_control_a <= `RESET_BYTE;
            timer_control_b_reg <= `RESET_BYTE;
            timer_mask_reg <= 3'h0;
        end else if (wr_en) begin
            if (paddr == `ADDR_CTRL_A) begin
                timer_control_a <= pwdata[7:0];
            end
            if (wr_ctrl_b) begin
                // strobes never store
                timer_control_b_reg <= {2'h0, pwdata[5:0]};
            end
            if (paddr == `ADDR_MASK) begin
                timer_mask_reg <= pwdata[2:0]; // RULE2
            end
        end
    end

    // compare values: buffer in pwm modes, update at top
    always_ff @(posedge mclk) begin
        if (reset) begin
            compare_value_a <= `RESET_BYTE; // RULE25
            compare_value_b <= `RESET_BYTE;
            buffer_a_reg <= `RESET_BYTE;
            buffer_b_reg <= `RESET_BYTE;
        end else begin
            if (wr_en && paddr == `ADDR_CMP_A) begin
                buffer_a_reg <= pwdata[7:0]; // RULE16
            end
            if (wr_en && paddr == `ADDR_CMP_B) begin
                buffer_b_reg <= pwdata[7:0];
            end
            if (!pwm_mode) begin
                if (wr_en && paddr == `ADDR_CMP_A) begin
                    compare_value_a <= pwdata[7:0]; // RULE16
                end
                if (wr_en && paddr == `ADDR_CMP_B) begin
                    compare_value_b <= pwdata[7:0];
                end
            end else if (timer_tick && ((fast_mode && at_top) ||
                    (dual_slope && at_top && dir_reg == dir_up))) begin
                compare_value_a <= buffer_a_reg; // RULE15
                compare_value_b <= buffer_b_reg;
            end
        end
    end

    // flags: hardware set beats software clear
    logic [2:0] flag_set;
    logic [2:0] flag_clr;
    always_comb begin
        flag_set = 3'h0;
        flag_clr = {ack_match_b, ack_match_a, ack_overflow}; // RULE12
        if (wr_flag) begin
            flag_clr = flag_clr | pwdata[2:0]; // RULE12
        end
        if (timer_tick && !block_reg) begin
            flag_set[`FLAG_MA] = match_a; // RULE11
            flag_set[`FLAG_MB] = match_b;
        end
        if (timer_tick && !wr_counter) begin
            if (dual_slope) begin
                flag_set[`FLAG_OVF] = at_bottom && dir_reg == dir_down;
            end else if (fast_mode) begin
                flag_set[`FLAG_OVF] = at_top; // RULE10
            end else begin
                flag_set[`FLAG_OVF] = counter_value == `CNT_MAX; // RULE24
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            timer_flag_reg <= 3'h0; // RULE25
        end else begin
            timer_flag_reg <= (timer_flag_reg & ~flag_clr) | flag_set;
        end
    end

    assign irq_overflow = timer_flag_reg[`FLAG_OVF] &
        timer_mask_reg[`FLAG_OVF]; // RULE2 RULE10
    assign irq_match_a = timer_flag_reg[`FLAG_MA] & timer_mask_reg[`FLAG_MA];
    assign irq_match_b = timer_flag_reg[`FLAG_MB] & timer_mask_reg[`FLAG_MB];

    // output action for one channel
    function automatic logic wave_step(input logic cur,
            input logic [1:0] action, input logic hit, input logic bot,
            input logic pwm, input logic fast, input logic down);
        logic v;
        v = cur;
        if (!pwm) begin
            if (hit) begin
                case (action)
                    `COM_TOGGLE: v = ~cur;
                    `COM_CLEAR: v = 1'b0;
                    `COM_SET: v = 1'b1;
                    default: v = cur;
                endcase
            end
        end else if (action[1]) begin
            // action[0] selects inverted output
            if (fast && hit) begin
                v = action[0];
            end else if (fast && bot) begin
                v = ~action[0];
            end else if (!fast && hit) begin
                v = down ? ~action[0] : action[0];
            end
        end
        return v;
    endfunction

    // wave state: kept across mode changes, moved by matches, the fast pwm top and force strobes
    always_ff @(posedge mclk) begin
        if (reset) begin
            wave_a_reg <= 1'b0; // RULE23
            wave_b_reg <= 1'b0;
        end else begin
            if (chan_a.force_strobe && !pwm_mode) begin
                wave_a_reg <= wave_step(wave_a_reg, chan_a.action, 1'b1,
                    1'b0, 1'b0, 1'b0, 1'b0); // RULE17
            end else if (timer_tick) begin
                wave_a_reg <= wave_step(wave_a_reg, chan_a.action,
                    match_a & ~block_reg, at_top, pwm_mode, fast_mode,
                    dir_reg == dir_down); // RULE13 RULE19
            end
            if (chan_b.force_strobe && !pwm_mode) begin
                wave_b_reg <= wave_step(wave_b_reg, chan_b.action, 1'b1,
                    1'b0, 1'b0, 1'b0, 1'b0); // RULE17
            end else if (timer_tick) begin
                wave_b_reg <= wave_step(wave_b_reg, chan_b.action,
                    match_b & ~block_reg, at_top, pwm_mode, fast_mode,
                    dir_reg == dir_down); // RULE13
            end
        end
    end

    assign wave_out_a = wave_a_reg;
    assign wave_out_b = wave_b_reg;
    assign wave_en_a = chan_a.action != `COM_NONE; // RULE20
    assign wave_en_b = chan_b.action != `COM_NONE;

    // read mux; buffered compare read in pwm modes
    always_comb begin
        prdata = 32'h0;
        pslverr = 1'b0;
        case (paddr)
            `ADDR_CTRL_A: prdata[7:0] = timer_control_a;
            `ADDR_CTRL_B: prdata[7:0] = timer_control_b_reg;
            `ADDR_COUNTER: prdata[7:0] = counter_value;
            `ADDR_CMP_A: prdata[7:0] = pwm_mode ? buffer_a_reg :
                compare_value_a; // RULE16
            `ADDR_CMP_B: prdata[7:0] = pwm_mode ? buffer_b_reg :
                compare_value_b;
            `ADDR_MASK: prdata[2:0] = timer_mask_reg;
            `ADDR_FLAG: prdata[2:0] = timer_flag_reg;
            `ADDR_STATUS: prdata[1:0] = {wave_b_reg, wave_a_reg};
            default: pslverr = psel & penable;
        endcase
    end

    // blocking, stop, wrap, clear at top and buffering guards
    blocked_match_a: assert property (@(posedge mclk) // RULE18
        disable iff (reset) timer_tick && block_reg |=>
        !$rose(timer_flag_reg[`FLAG_MA]) && !$rose(timer_flag_reg[`FLAG_MB]))
        else $error("match flag after counter write");
    stop_hold_a: assert property (@(posedge mclk) disable iff (reset) // RULE4
        (clock_select_field == `CS_STOP && !wr_counter) |=>
        $stable(counter_value)) else $error("counter moved while stopped");
    normal_wrap_a: assert property (@(posedge mclk) // RULE24
        disable iff (reset) waveform_mode_field == `WGM_NORMAL &&
        timer_tick && !wr_counter && counter_value == `CNT_MAX |=>
        counter_value == `CNT_BOTTOM && timer_flag_reg[`FLAG_OVF])
        else $error("normal wrap wrong");
    ctc_clear_a: assert property (@(posedge mclk) disable iff (reset) // RULE6
        waveform_mode_field == `WGM_CTC && timer_tick && at_top && !wr_counter
        |=> counter_value == `CNT_BOTTOM) else $error("no clear at top");
    buffer_copy_a: assert property (@(posedge mclk) // RULE15
        disable iff (reset) fast_mode && timer_tick && at_top |=>
        compare_value_a == $past(buffer_a_reg)) else $error("no copy at top");
    pwm_hold_a: assert property (@(posedge mclk) disable iff (reset) // RULE16
        pwm_mode && !timer_tick && wr_en && paddr == `ADDR_CMP_A |=>
        $stable(compare_value_a)) else $error("direct compare write in pwm");
endmodule

/* File: sim/tb_timer8_counter_compare_core.sv */
`timescale 1ns/1ps
`include "timer8_defines.svh"

module tb_timer8_counter_compare_core;
    // clock, reset and apb
    logic mclk;
    logic reset;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    // timer side
    logic prescale_tick;
    logic ext_count_pin;
    logic ack_overflow;
    logic ack_match_a;
    logic ack_match_b;
    logic irq_overflow;
    logic irq_match_a;
    logic irq_match_b;
    logic wave_out_a;
    logic wave_out_b;
    logic wave_en_a;
    logic wave_en_b;
    // bench state
    int n_fail;
    int checked;
    logic [31:0] rdata;
    logic rerr;

    timer8_counter_compare_core u_timer8_counter_compare_core (
        .mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .prescale_tick(prescale_tick), .ext_count_pin(ext_count_pin),
        .ack_overflow(ack_overflow), .ack_match_a(ack_match_a),
        .ack_match_b(ack_match_b), .irq_overflow(irq_overflow),
        .irq_match_a(irq_match_a), .irq_match_b(irq_match_b),
        .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
        .wave_en_a(wave_en_a), .wave_en_b(wave_en_b)
    );

    // 200 mhz clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one apb transfer; tk holds a timer tick over the taking edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic tk);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        prescale_tick <= tk;
        // wait as long as the slave asks; only the watchdog bounds it
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        prescale_tick <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d}, 1'b0);
    endtask

    // read, mask and compare
    task automatic rd(input logic [11:0] a, input logic [31:0] m,
                      input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0, 1'b0);
        check(nm, rdata & m, exp);
    endtask

    // n single-cycle prescaler ticks, then let outputs settle
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge mclk);
            prescale_tick <= 1'b1;
            @(posedge mclk);
            prescale_tick <= 1'b0;
        end
        @(posedge mclk);
        #1;
    endtask

    // interrupt-service acknowledge pulses {b, a, ovf}
    task automatic ack(input logic [2:0] m);
        @(posedge mclk);
        ack_overflow <= m[0];
        ack_match_a <= m[1];
        ack_match_b <= m[2];
        @(posedge mclk);
        ack_overflow <= 1'b0;
        ack_match_a <= 1'b0;
        ack_match_b <= 1'b0;
    endtask

    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        finish_test();
    end

    initial begin
        n_fail = 0;
        checked = 0;
        reset = 1'b1;
        {psel, penable, pwrite, prescale_tick, ext_count_pin} = 5'h0;
        {ack_overflow, ack_match_a, ack_match_b} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        // every mapped register starts at zero
        for (int i = 0; i < 8; i++) begin
            rd(12'(4 * i), '1, 32'h0, "reset value");
        end
        apb(1'b0, 12'h020, 32'h0, 1'b0);
        check("unmapped err", {31'h0, rerr}, 32'h1);
        check("unmapped data", rdata, 32'h0);
        // width, direct compare access, stopped counter
        apb(1'b1, `ADDR_COUNTER, 32'hffffff5a, 1'b0);
        rd(`ADDR_COUNTER, '1, 32'h5a, "counter width");
        wr(`ADDR_CMP_A, 8'ha5);
        rd(`ADDR_CMP_A, '1, 32'ha5, "cmp a");
        wr(`ADDR_CMP_B, 8'hc3);
        rd(`ADDR_CMP_B, '1, 32'hc3, "cmp b");
        pulse(3);
        rd(`ADDR_COUNTER, '1, 32'h5a, "stopped");
        // cpu write beats a simultaneous tick
        wr(`ADDR_CTRL_B, 8'h01);
        apb(1'b1, `ADDR_COUNTER, 32'h30, 1'b1);
        rd(`ADDR_COUNTER, '1, 32'h30, "write priority");
        pulse(1);
        rd(`ADDR_COUNTER, '1, 32'h31, "increment");
        // normal mode wrap and overflow
        wr(`ADDR_FLAG, 8'h07);
        wr(`ADDR_MASK, 8'h01);
        wr(`ADDR_COUNTER, 8'hfe);
        pulse(1);
        rd(`ADDR_COUNTER, '1, 32'hff, "max");
        rd(`ADDR_FLAG, 32'h1, 32'h0, "ovf early");
        pulse(1);
        rd(`ADDR_COUNTER, '1, 32'h0, "wrap");
        rd(`ADDR_FLAG, 32'h1, 32'h1, "ovf flag");
        #1;
        check("irq ovf", {31'h0, irq_overflow}, 32'h1);
        wr(`ADDR_FLAG, 8'h01);
        rd(`ADDR_FLAG, 32'h1, 32'h0, "ovf w1c");
        // match sets flags one tick late; toggle both outputs
        wr(`ADDR_CTRL_A, 8'h50);
        wr(`ADDR_CMP_A, 8'h05);
        wr(`ADDR_CMP_B, 8'h05);
        wr(`ADDR_FLAG, 8'h07);
        wr(`ADDR_MASK, 8'h06);
        wr(`ADDR_COUNTER, 8'h04);
        pulse(1);
        rd(`ADDR_FLAG, 32'h6, 32'h0, "match early");
        rd(`ADDR_STATUS, 32'h3, 32'h0, "wave early");
        pulse(1);
        rd(`ADDR_FLAG, 32'h6, 32'h6, "match flags");
        rd(`ADDR_STATUS, 32'h3, 32'h3, "wave toggle");
        #1;
        check("irq match", {30'h0, irq_match_b, irq_match_a}, 32'h3);
        check("wave b", {30'h0, wave_en_b, wave_out_b}, 32'h3);
        ack(3'b011);
        rd(`ADDR_FLAG, 32'h6, 32'h4, "ack clear");
        wr(`ADDR_FLAG, 8'h04);
        rd(`ADDR_FLAG, 32'h6, 32'h0, "b w1c");
        // counter write while stopped blocks the next match
        wr(`ADDR_CTRL_B, 8'h00);
        wr(`ADDR_CMP_B, 8'h10);
        wr(`ADDR_COUNTER, 8'h10);
        wr(`ADDR_CTRL_B, 8'h01);
        pulse(1);
        rd(`ADDR_COUNTER, '1, 32'h11, "after block");
        rd(`ADDR_FLAG, 32'h4, 32'h0, "blocked");
        // external pin, rising then falling edge
        wr(`ADDR_CTRL_B, 8'h07);
        wr(`ADDR_COUNTER, 8'h20);
        @(posedge mclk);
        ext_count_pin <= 1'b1;
        repeat (8) @(posedge mclk);
        rd(`ADDR_COUNTER, '1, 32'h21, "pin rise");
        wr(`ADDR_CTRL_B, 8'h06);
        @(posedge mclk);
        ext_count_pin <= 1'b0;
        repeat (8) @(posedge mclk);
        rd(`ADDR_COUNTER, '1, 32'h22, "pin fall");
        pulse(1);
        rd(`ADDR_COUNTER, '1, 32'h22, "prescale ignored");
        // clear on compare: top is compare a
        wr(`ADDR_CTRL_B, 8'h00);
        wr(`ADDR_CTRL_A, 8'h02);
        #1;
        check("en a off", {31'h0, wave_en_a}, 32'h0);
        wr(`ADDR_CMP_A, 8'h03);
        wr(`ADDR_COUNTER, 8'h02);
        wr(`ADDR_CTRL_B, 8'h01);
        pulse(1);
        rd(`ADDR_COUNTER, '1, 32'h3, "ctc top");
        pulse(1);
        rd(`ADDR_COUNTER, '1, 32'h0, "ctc clear");
        // force strobe: output moves, flag and counter do not
        wr(`ADDR_CTRL_B, 8'h00);
        wr(`ADDR_CTRL_A, 8'h80);
        #1;
        check("en a on", {31'h0, wave_en_a}, 32'h1);
        wr(`ADDR_FLAG, 8'h07);
        wr(`ADDR_COUNTER, 8'h33);
        wr(`ADDR_CTRL_B, 8'h80);
        #1;
        check("force clear", {31'h0, wave_out_a}, 32'h0);
        wr(`ADDR_CTRL_A, 8'hc0);
        wr(`ADDR_CTRL_B, 8'h80);
        #1;
        check("force set", {31'h0, wave_out_a}, 32'h1);
        rd(`ADDR_COUNTER, '1, 32'h33, "force count");
        rd(`ADDR_FLAG, 32'h2, 32'h0, "force flag");
        rd(`ADDR_CTRL_B, '1, 32'h0, "strobe reads 0");
        wr(`ADDR_CTRL_A, 8'hc1);
        #1;
        check("mode change", {31'h0, wave_out_a}, 32'h1);
        // force has no effect in pwm modes
        wr(`ADDR_CTRL_A, 8'h81);
        wr(`ADDR_CTRL_B, 8'h80);
        #1;
        check("pwm force", {31'h0, wave_out_a}, 32'h1);
        // fast pwm: write lands in buffer, copied at top
        wr(`ADDR_CTRL_A, 8'h03);
        wr(`ADDR_FLAG, 8'h07);
        wr(`ADDR_CMP_A, 8'h12);
        rd(`ADDR_CMP_A, '1, 32'h12, "buffer read");
        wr(`ADDR_COUNTER, 8'h11);
        wr(`ADDR_CTRL_B, 8'h01);
        pulse(2);
        rd(`ADDR_FLAG, 32'h2, 32'h0, "buffered");
        wr(`ADDR_COUNTER, 8'hfe);
        pulse(2);
        rd(`ADDR_COUNTER, '1, 32'h0, "fast wrap");
        wr(`ADDR_FLAG, 8'h07);
        wr(`ADDR_COUNTER, 8'h11);
        pulse(2);
        rd(`ADDR_FLAG, 32'h2, 32'h2, "copied at top");
        // phase correct: turns down at top, overflow at bottom
        wr(`ADDR_CTRL_A, 8'h01);
        wr(`ADDR_FLAG, 8'h07);
        wr(`ADDR_COUNTER, 8'hfe);
        pulse(3);
        rd(`ADDR_COUNTER, '1, 32'hfd, "dual down");
        wr(`ADDR_COUNTER, 8'h01);
        pulse(2);
        rd(`ADDR_COUNTER, '1, 32'h01, "dual turn");
        rd(`ADDR_FLAG, 32'h1, 32'h1, "dual ovf");
        finish_test();
    end
endmodule
